// ===== hw/asp_serial_ctrl.sv
// Async serial port with its two control registers behind an AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Enabled port forces receive pin as input
// - Loopback routes transmitter output into receiver
// - Module enable runs port; clearing sets tx flags
// - Polarity invert flips every transmitted level
// - Character length bit selects nine or eight
// - Wakeup bit selects address mark or idle
// - Idle count starts after stop or start
// - Parity bit occupies character's most significant bit
// - Parity select: odd when set, even clear
// - One start, one stop; ten or eleven
// - Tx empty/done enables gate transmitter interrupt
// - Rx full/idle enables gate receiver interrupt
// - Tx enable rising sends all-ones preamble first
// - Tx disable finishes current character, then idles
// - Tx off-then-on mid character queues idle character
// - Rx disable stops receiver, keeps its flags
// - Standby suppresses rx interrupts; wakeup clears it
// - Break then release sends one trailing one
// - Held break sends breaks back to back
// - Break before preamble replaces the preamble
// - Ten or eleven consecutive ones mean idle
module asp_serial_ctrl
	import asp_pkg::*;
#(
	parameter logic [15:0] BAUD_DIV_RST = BAUD_DIV_DEF
)(
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic             tx_pin_o,
	output logic             tx_pin_oe_o,
	input  wire logic        rx_pin_i,
	input  wire logic        port_dir_bit1_i,
	input  wire logic        port_out1_i,
	output logic             rx_pin_o,
	output logic             rx_pin_oe_o,
	output logic             tx_irq_o,
	output logic             rx_irq_o
);

	// ==========================================================
	// Declarations
	asp_ctrl_a_type   ca_q;
	asp_ctrl_b_type   cb_q;
	asp_tx_state_type tx_st_q;
	asp_rx_state_type rx_st_q;
	logic [15:0] baud_q;
	logic [8:0]  tdata_q;
	logic [8:0]  rdata_q;
	logic [7:0]  stat_q;
	logic [31:0] hrdata_q;
	logic        wr_q;
	logic [7:0]  widx_q;
	logic        clr_arm_q;
	logic [15:0] tx_bcnt_q;
	logic [15:0] rx_bcnt_q;
	logic [10:0] tx_sh_q;
	logic [3:0]  tx_left_q;
	logic        tx_brk_q;
	logic        pre_pend_q;
	logic        txon_prev_q;
	logic        tx_pin_q;
	logic        rx_s1_q;
	logic        rx_s2_q;
	logic [10:0] rx_sh_q;
	logic [3:0]  rx_left_q;
	logic [3:0]  ones_q;
	logic        armed_q;
	logic        tx_irq_q;
	logic        rx_irq_q;

	logic        en;
	logic        acc;
	logic [7:0]  aidx;
	logic        stat_rd;
	logic        data_rd;
	logic        data_wr;
	logic        rx_clr;
	logic [3:0]  flen;
	logic        tx_tick;
	logic        rx_tick;
	logic        tx_raw;
	logic        tx_last;
	logic        ld_go;
	logic        ld_data;
	logic        ld_brk;
	logic        ld_pre;
	logic [10:0] ld_sh;
	logic [3:0]  ld_left;
	logic        pbit;
	logic [8:0]  word9;
	logic [10:0] frame;
	logic        rx_en;
	logic        rx_line;
	logic [3:0]  rx_pos;
	logic        rx_done;
	logic [8:0]  rx_word;
	logic        rx_msb;
	logic        rx_perr;
	logic        rx_isbrk;
	logic        rx_keep;
	logic        rx_wake;
	logic        idle_hit;

	assign en   = ca_q.module_enable;
	assign flen = ca_q.char_nine ? FRAME_LEN_9 : FRAME_LEN_8;

	// ==========================================================
	// AHB-Lite slave: zero wait states, always OKAY
	assign acc         = hsel_i & htrans_i[1] & hready_i;
	assign aidx        = haddr_i[9:2];
	assign stat_rd     = acc & ~hwrite_i & (aidx == IDX_STATUS);
	assign data_rd     = acc & ~hwrite_i & (aidx == IDX_DATA);
	assign data_wr     = wr_q & (widx_q == IDX_DATA);
	assign rx_clr      = data_rd & clr_arm_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = hrdata_q;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wr_q   <= 1'b0;
			widx_q <= 8'h00;
		end
		else
		begin
			wr_q   <= acc & hwrite_i;
			widx_q <= aidx;
		end
	end

	// Read data is captured in the address phase so side effects line up with it
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			hrdata_q <= 32'h0000_0000;
		else if (acc & ~hwrite_i)
		begin
			case (aidx)
				IDX_CTRL_A: hrdata_q <= {24'h00_0000, ca_q};
				IDX_CTRL_B: hrdata_q <= {24'h00_0000, cb_q};
				IDX_STATUS: hrdata_q <= {24'h00_0000, stat_q};
				IDX_DATA:   hrdata_q <= {23'h00_0000, rdata_q};
				IDX_BAUD:   hrdata_q <= {16'h0000, baud_q};
				default:    hrdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Status read arms the clear; the following data read completes it
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			clr_arm_q <= 1'b0;
		else if (stat_rd)
			clr_arm_q <= |stat_q[ST_BREAK:ST_RX_FULL];
		else if (data_rd)
			clr_arm_q <= 1'b0;
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ca_q    <= CTRL_A_RST;
			baud_q  <= BAUD_DIV_RST;
			tdata_q <= 9'h000;
		end
		else if (wr_q)
		begin
			if (widx_q == IDX_CTRL_A)
				ca_q <= hwdata_i[7:0];
			if (widx_q == IDX_BAUD)
				baud_q <= hwdata_i[15:0];
			if (widx_q == IDX_DATA)
				tdata_q <= hwdata_i[8:0];
		end
	end

	// Software write wins over a wakeup that lands in the same cycle
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cb_q <= CTRL_B_RST;
		else if (wr_q && widx_q == IDX_CTRL_B)
			cb_q <= hwdata_i[7:0];
		else if (rx_wake)
			cb_q.rx_standby <= 1'b0;
	end

	// ==========================================================
	// Pins
	assign tx_pin_o    = tx_pin_q;
	assign tx_pin_oe_o = en;
	assign rx_pin_o    = port_out1_i;
	assign rx_pin_oe_o = en ? 1'b0 : port_dir_bit1_i;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rx_s1_q  <= 1'b1;
			rx_s2_q  <= 1'b1;
			tx_pin_q <= 1'b1;
		end
		else
		begin
			rx_s1_q  <= rx_pin_i;
			rx_s2_q  <= rx_s1_q;
			tx_pin_q <= tx_raw ^ ca_q.tx_polarity_invert;
		end
	end

	// ==========================================================
	// Bit-time generators, both stopped while the port is off
	assign tx_tick = en & (tx_bcnt_q == 16'h0000);
	assign rx_tick = rx_en & (rx_bcnt_q == 16'h0000);

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			tx_bcnt_q <= 16'h0000;
		else if (!en || tx_bcnt_q == 16'h0000)
			tx_bcnt_q <= baud_q;
		else
			tx_bcnt_q <= tx_bcnt_q - 16'h0001;
	end

	// ==========================================================
	// Transmit frame assembly
	assign pbit = (ca_q.char_nine ? ^tdata_q[7:0] : ^tdata_q[6:0])
		^ ca_q.parity_odd_sel;

	always_comb
	begin
		if (ca_q.parity_on)
			word9 = ca_q.char_nine ? {pbit, tdata_q[7:0]}
				: {1'b0, pbit, tdata_q[6:0]};
		else
			word9 = ca_q.char_nine ? tdata_q : {1'b0, tdata_q[7:0]};
		frame = ca_q.char_nine ? {1'b1, word9, 1'b0}
			: {2'b11, word9[7:0], 1'b0};
	end

	// ==========================================================
	// Transmit source selection, evaluated when idle or on a frame's last bit
	assign tx_last = (tx_st_q == TX_SHIFT) & (tx_left_q == 4'h1);
	assign tx_raw  = (tx_st_q == TX_SHIFT) ? tx_sh_q[0] : 1'b1;

	always_comb
	begin
		ld_go   = 1'b0;
		ld_data = 1'b0;
		ld_brk  = 1'b0;
		ld_pre  = 1'b0;
		ld_sh   = 11'h7ff;
		ld_left = flen;
		if (tx_tick && (tx_st_q == TX_IDLE || tx_last))
		begin
			if (tx_brk_q && tx_last && !cb_q.send_brk)
			begin
				ld_go   = 1'b1;
				ld_left = 4'h1;
			end
			else if (cb_q.send_brk && cb_q.tx_on)
			begin
				ld_go  = 1'b1;
				ld_brk = 1'b1;
				ld_sh  = 11'h000;
			end
			else if (pre_pend_q)
			begin
				ld_go  = 1'b1;
				ld_pre = 1'b1;
			end
			else if (!stat_q[ST_TX_EMPTY] && cb_q.tx_on)
			begin
				ld_go   = 1'b1;
				ld_data = 1'b1;
				ld_sh   = frame;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tx_st_q   <= TX_IDLE;
			tx_sh_q   <= 11'h7ff;
			tx_left_q <= 4'h0;
			tx_brk_q  <= 1'b0;
		end
		else if (!en)
		begin
			tx_st_q  <= TX_IDLE;
			tx_brk_q <= 1'b0;
		end
		else if (ld_go)
		begin
			tx_st_q   <= TX_SHIFT;
			tx_sh_q   <= ld_sh;
			tx_left_q <= ld_left;
			tx_brk_q  <= ld_brk;
		end
		else if (tx_tick)
		begin
			case (tx_st_q)
				TX_SHIFT:
				begin
					tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
					tx_left_q <= tx_left_q - 4'h1;
					if (tx_last)
					begin
						tx_st_q  <= TX_IDLE;
						tx_brk_q <= 1'b0;
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// Preamble request on each rising edge of the transmitter enable while the port is enabled
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pre_pend_q  <= 1'b0;
			txon_prev_q <= 1'b0;
		end
		else
		begin
			txon_prev_q <= cb_q.tx_on;
			if (en && cb_q.tx_on && !txon_prev_q)
				pre_pend_q <= 1'b1;
			else if (!en || ld_pre || ld_brk)
				pre_pend_q <= 1'b0;
		end
	end

	// ==========================================================
	// Receiver
	assign rx_en   = en & cb_q.rx_on;
	assign rx_line = ca_q.loopback_select ? tx_raw : rx_s2_q;
	assign rx_pos  = flen - rx_left_q;
	assign rx_done = rx_tick & (rx_st_q == RX_FRAME) & (rx_left_q == 4'h1) & ~rx_sh_q[0];
	assign rx_word = ca_q.char_nine ? rx_sh_q[9:1] : {rx_sh_q[8], rx_sh_q[8:1]};
	assign rx_msb  = ca_q.char_nine ? rx_sh_q[9] : rx_sh_q[8];
	assign rx_perr = ca_q.parity_on & (((ca_q.char_nine ? ^rx_sh_q[9:1] : ^rx_sh_q[8:1]))
		!= ca_q.parity_odd_sel);
	assign rx_isbrk = ~rx_line & ~(ca_q.char_nine ? |rx_sh_q[9:0] : |rx_sh_q[8:0]);
	// Standby drops characters unless an address mark wakes it
	assign rx_keep  = ~cb_q.rx_standby | (ca_q.wake_addr_mark & rx_msb);
	assign idle_hit = rx_tick & rx_line & (ones_q == flen - 4'h1);
	assign rx_wake  = cb_q.rx_standby & ((rx_done & ca_q.wake_addr_mark & rx_msb)
		| (idle_hit & ~ca_q.wake_addr_mark));

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rx_st_q   <= RX_IDLE;
			rx_bcnt_q <= 16'h0000;
			rx_left_q <= 4'h0;
			rx_sh_q   <= 11'h000;
		end
		else if (!rx_en)
		begin
			rx_st_q   <= RX_IDLE;
			rx_bcnt_q <= baud_q;
		end
		else
		begin
			rx_bcnt_q <= rx_tick ? baud_q : rx_bcnt_q - 16'h0001;
			case (rx_st_q)
				RX_IDLE:
					if (!rx_line)
					begin
						// Half a bit time lands samples mid-bit
						rx_st_q   <= RX_FRAME;
						rx_bcnt_q <= {1'b0, baud_q[15:1]};
						rx_left_q <= flen;
					end
				RX_FRAME:
					if (rx_tick)
					begin
						rx_sh_q[rx_pos] <= rx_line;
						rx_left_q       <= rx_left_q - 4'h1;
						if ((rx_left_q == flen && rx_line) || rx_left_q == 4'h1)
							rx_st_q <= RX_IDLE;
					end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Consecutive ones; with count-after-stop the frame itself never counts
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ones_q <= 4'h0;
		else if (!rx_en)
			ones_q <= 4'h0;
		else if (rx_tick)
		begin
			if (!rx_line || (ca_q.idle_count_start_sel && rx_st_q == RX_FRAME))
				ones_q <= 4'h0;
			else if (ones_q != flen)
				ones_q <= ones_q + 4'h1;
		end
	end

	// ==========================================================
	// Status flags; hardware set wins over the software clear
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			stat_q  <= 8'h03;
			rdata_q <= 9'h000;
			armed_q <= 1'b0;
		end
		else
		begin
			if (!en || ld_data)
				stat_q[ST_TX_EMPTY] <= 1'b1;
			else if (data_wr)
				stat_q[ST_TX_EMPTY] <= 1'b0;
			stat_q[ST_TX_DONE] <= ~en | (stat_q[ST_TX_EMPTY] & ~data_wr
				& (tx_st_q == TX_IDLE) & ~ld_go & ~pre_pend_q);
			if (rx_done && rx_keep)
			begin
				if (stat_q[ST_RX_FULL] && !rx_clr)
					stat_q[ST_OVERRUN] <= 1'b1;
				else
				begin
					rdata_q             <= rx_isbrk ? 9'h000 : rx_word;
					stat_q[ST_RX_FULL]  <= 1'b1;
					stat_q[ST_FRAMING]  <= ~rx_line;
					stat_q[ST_PARITY]   <= rx_perr;
					stat_q[ST_BREAK]    <= rx_isbrk;
					stat_q[ST_OVERRUN]  <= 1'b0;
				end
				armed_q <= 1'b1;
			end
			else if (rx_clr)
			begin
				stat_q[ST_RX_FULL] <= 1'b0;
				stat_q[ST_OVERRUN] <= 1'b0;
				stat_q[ST_FRAMING] <= 1'b0;
				stat_q[ST_PARITY]  <= 1'b0;
				stat_q[ST_BREAK]   <= 1'b0;
			end
			if (idle_hit && armed_q && !cb_q.rx_standby)
			begin
				stat_q[ST_IDLE] <= 1'b1;
				armed_q         <= 1'b0;
			end
			else if (rx_clr)
				stat_q[ST_IDLE] <= 1'b0;
			if (!rx_en)
				armed_q <= 1'b0;
		end
	end

	// ==========================================================
	// Interrupt requests
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
		end
		else
		begin
			tx_irq_q <= en & ((stat_q[ST_TX_EMPTY] & cb_q.tx_empty_irq_en)
				| (stat_q[ST_TX_DONE] & cb_q.tx_done_irq_en));
			rx_irq_q <= ~cb_q.rx_standby & ((stat_q[ST_RX_FULL] & cb_q.rx_full_irq_en)
				| (stat_q[ST_IDLE] & cb_q.idle_irq_en));
		end
	end

	assign tx_irq_o = tx_irq_q;
	assign rx_irq_o = rx_irq_q;

endmodule // asp_serial_ctrl

// ===== hw/asp_pkg.sv
// Package: register map, field layouts and constants of the serial control block
package asp_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_CTRL_A = 8'h13;
	localparam logic [7:0] IDX_CTRL_B = 8'h14;
	localparam logic [7:0] IDX_STATUS = 8'h15;
	localparam logic [7:0] IDX_DATA   = 8'h16;
	localparam logic [7:0] IDX_BAUD   = 8'h17;

	// ==========================================================
	// Reset values
	localparam logic [7:0]  CTRL_A_RST   = 8'h00;
	localparam logic [7:0]  CTRL_B_RST   = 8'h00;
	localparam logic [15:0] BAUD_DIV_DEF = 16'h00a2;

	// ==========================================================
	// Status bit positions
	localparam int ST_TX_EMPTY = 0;
	localparam int ST_TX_DONE  = 1;
	localparam int ST_RX_FULL  = 2;
	localparam int ST_IDLE     = 3;
	localparam int ST_OVERRUN  = 4;
	localparam int ST_FRAMING  = 5;
	localparam int ST_PARITY   = 6;
	localparam int ST_BREAK    = 7;

	// ==========================================================
	// Frame lengths in bit times, start and stop included
	localparam logic [3:0] FRAME_LEN_8 = 4'ha;
	localparam logic [3:0] FRAME_LEN_9 = 4'hb;

	// ==========================================================
	// Field layouts, bit 7 first
	typedef struct packed {
		logic loopback_select;
		logic module_enable;
		logic tx_polarity_invert;
		logic char_nine;
		logic wake_addr_mark;
		logic idle_count_start_sel;
		logic parity_on;
		logic parity_odd_sel;
	} asp_ctrl_a_type;

	typedef struct packed {
		logic tx_empty_irq_en;
		logic tx_done_irq_en;
		logic rx_full_irq_en;
		logic idle_irq_en;
		logic tx_on;
		logic rx_on;
		logic rx_standby;
		logic send_brk;
	} asp_ctrl_b_type;

	typedef enum logic {TX_IDLE, TX_SHIFT} asp_tx_state_type;
	typedef enum logic {RX_IDLE, RX_FRAME} asp_rx_state_type;

endpackage

// ===== sim/asp_monitor.sv
// Port checker of the serial control block, bound to its top module
`timescale 1ns/1ps
module asp_monitor
	import asp_pkg::*;
#(
	parameter logic [15:0] BAUD_DIV_RST = BAUD_DIV_DEF
)(
	input wire logic        core_clk_i,
	input wire logic        resetn_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic        tx_pin_o,
	input wire logic        tx_pin_oe_o,
	input wire logic        port_dir_bit1_i,
	input wire logic        port_out1_i,
	input wire logic        rx_pin_o,
	input wire logic        rx_pin_oe_o,
	input wire logic        tx_irq_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// ==========================================================
	// Cycles since the transmit line last moved
	logic        tx_prev_q;
	logic [15:0] gap_q;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tx_prev_q <= 1'b1;
			gap_q     <= 16'h0000;
		end
		else
		begin
			tx_prev_q <= tx_pin_o;
			if (tx_pin_o != tx_prev_q)
				gap_q <= 16'h0000;
			else if (gap_q != 16'hffff)
				gap_q <= gap_q + 16'h0001;
		end
	end

	sequence s_tx_flip;
		tx_pin_o != tx_prev_q;
	endsequence

	// ==========================================================
	// Assertions
	a_ready_high: assert property (hreadyout_o)
		else $error("slave inserted a wait state");
	a_resp_okay: assert property (!hresp_o)
		else $error("slave gave an error response");
	a_rx_pin_input: assert property (tx_pin_oe_o |-> !rx_pin_oe_o)
		else $error("receive pin driven while port enabled");
	a_rx_dir_pass: assert property (!tx_pin_oe_o |-> rx_pin_oe_o == port_dir_bit1_i)
		else $error("receive pin direction ignores port bit");
	a_rx_out_pass: assert property (rx_pin_o == port_out1_i)
		else $error("receive pin output level wrong");
	a_tx_irq_off: assert property (!tx_pin_oe_o [*2] |-> !tx_irq_o)
		else $error("transmit request while port disabled");
	a_bit_hold: assert property (s_tx_flip |-> gap_q >= BAUD_DIV_RST)
		else $error("transmit bit shorter than one bit time");
	a_rdata_width: assert property (hrdata_o[31:9] == 23'h000000)
		else $error("read data upper bits not zero");
endmodule // asp_monitor

bind asp_serial_ctrl asp_monitor #(.BAUD_DIV_RST(BAUD_DIV_RST)) u_asp_monitor (
	.core_clk_i      (core_clk_i),
	.resetn_i        (resetn_i),
	.hrdata_o        (hrdata_o),
	.hreadyout_o     (hreadyout_o),
	.hresp_o         (hresp_o),
	.tx_pin_o        (tx_pin_o),
	.tx_pin_oe_o     (tx_pin_oe_o),
	.port_dir_bit1_i (port_dir_bit1_i),
	.port_out1_i     (port_out1_i),
	.rx_pin_o        (rx_pin_o),
	.rx_pin_oe_o     (rx_pin_oe_o),
	.tx_irq_o        (tx_irq_o)
);

// ===== sim/asp_remote.sv
// Remote serial device: sends frames to the block and catches its frames
`timescale 1ns/1ps
module asp_remote #(
	parameter int BIT_CLKS = 4
)(
	input  wire logic        clk_i,
	input  wire logic        line_i,
	input  wire logic        inv_i,
	input  wire logic [3:0]  len_i,
	output logic             line_o,
	output logic [10:0]      frame_o,
	output logic             got_o
);
	logic        lvl;
	logic [10:0] f;

	assign lvl = line_i ^ inv_i;

	initial
	begin
		line_o  = 1'b1;
		got_o   = 1'b0;
		frame_o = 11'h000;
	end

	// ==========================================================
	// Sender: bits LSB first, line left high after the stop bit
	task automatic send(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_i);
			line_o <= bits[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		line_o <= 1'b1;
	endtask

	task automatic set_line(input logic v);
		@(posedge clk_i);
		line_o <= v;
	endtask

	// ==========================================================
	// Catcher: start confirmed at mid-bit, so short glitches are ignored
	always
	begin
		@(posedge clk_i);
		if (lvl === 1'b0)
		begin
			repeat (BIT_CLKS / 2) @(posedge clk_i);
			if (lvl === 1'b0)
			begin
				f = 11'h000;
				for (int i = 1; i < len_i; i++)
				begin
					repeat (BIT_CLKS) @(posedge clk_i);
					f[i] = lvl;
				end
				frame_o <= f;
				got_o   <= 1'b1;
				@(posedge clk_i);
				got_o   <= 1'b0;
			end
		end
	end
endmodule // asp_remote

// ===== sim/testbench.sv
// Self-checking bench of the serial control block
`timescale 1ns/1ps
module testbench;
	import asp_pkg::*;

	localparam logic [15:0] BAUD = 16'h0003;

	logic        clk, resetn, hsel, hwrite, hready_o, hresp, tx_pin, tx_oe, rx_pin;
	logic        dir_bit, out1, rx_o, rx_oe, tx_irq, rx_irq, inv, got;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd_last, wm;
	logic [3:0]  len;
	logic [10:0] frame;
	logic [8:0]  d;
	int          miscompares, checks_done, seed;
	logic [31:0] rq[$];
	logic [31:0] mq[$];
	logic [10:0] fq[$];
	event        rd_ev;
	asp_ctrl_a_type ca;
	logic [7:0]  fmts [7] = '{8'h40, 8'h50, 8'h42, 8'h43, 8'h52, 8'h53, 8'h60};
	logic [7:0]  tie  [3] = '{8'h8c, 8'h4c, 8'h0c};

	initial clk = 1'b0;
	always #20 clk = ~clk;

	asp_serial_ctrl #(.BAUD_DIV_RST(BAUD)) u_asp_serial_ctrl (
		.core_clk_i(clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
		.hready_i(hready_o), .hrdata_o(hrdata), .hreadyout_o(hready_o), .hresp_o(hresp),
		.tx_pin_o(tx_pin), .tx_pin_oe_o(tx_oe), .rx_pin_i(rx_pin),
		.port_dir_bit1_i(dir_bit), .port_out1_i(out1), .rx_pin_o(rx_o),
		.rx_pin_oe_o(rx_oe), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));

	asp_remote #(.BIT_CLKS(int'(BAUD) + 1)) u_asp_remote (
		.clk_i(clk), .line_i(tx_pin), .inv_i(inv), .len_i(len),
		.line_o(rx_pin), .frame_o(frame), .got_o(got));

	// ==========================================================
	// Checking and reporting
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(rd_ev)
	begin
		wm = mq.pop_front();
		cmp(rq.pop_front() & wm, rd_last & wm);
	end

	// A frame nobody expected compares against an impossible value
	always @(posedge clk)
		if (got === 1'b1)
			cmp(fq.size() != 0 ? {21'h0, fq.pop_front()} : 32'hffffffff, {21'h0, frame});

	always @(posedge clk)
	begin
		dir_bit <= 1'($random(seed));
		out1    <= 1'($random(seed));
	end

	initial
	begin
		repeat (40000) @(posedge clk);
		miscompares++;
		give_verdict();
	end

	// ==========================================================
	// Bus master and helpers
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {22'h000000, idx, 2'b00};
		hwrite <= wr;
		do @(posedge clk); while (hready_o !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hready_o !== 1'b1);
		rd_last = hrdata;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m);
		rq.push_back(e);
		mq.push_back(m);
		bus(1'b0, idx, 32'h00000000);
		-> rd_ev;
	endtask

	task automatic set_a(input logic [7:0] v);
		ca = v;
		len <= v[4] ? 4'hb : 4'ha;
		bus(1'b1, IDX_CTRL_A, {24'h000000, v});
		@(posedge clk);
		inv <= v[5];
	endtask

	function automatic logic [10:0] frm(input asp_ctrl_a_type a, input logic [8:0] v);
		int          m;
		logic [10:0] f;
		m = a.char_nine ? 9 : 8;
		if (a.parity_on)
		begin
			v[m-1] = a.parity_odd_sel;
			for (int i = 0; i < m - 1; i++)
				v[m-1] = v[m-1] ^ v[i];
		end
		f = 11'h000;
		for (int i = 0; i < m; i++)
			f[i+1] = v[i];
		f[m+1] = 1'b1;
		return f;
	endfunction

	task automatic drain;
		while (fq.size() != 0) @(posedge clk);
		repeat (8) @(posedge clk); // Quiet gap before any format change
	endtask

	task automatic send_char(input logic [8:0] v);
		fq.push_back(frm(ca, v));
		bus(1'b1, IDX_DATA, {23'h000000, v});
		drain();
	endtask

	task automatic rx_char(input logic [8:0] v);
		u_asp_remote.send(frm(ca, v), 10);
		repeat (4) @(posedge clk);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		seed = 32'h68b5;
		{resetn, hsel, hwrite, inv} = 4'h0;
		{htrans, haddr, hwdata} = '0;
		len = 4'ha;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rd(IDX_CTRL_A, 32'h00, 32'hff);
		rd(IDX_CTRL_B, 32'h00, 32'hff);
		rd(IDX_STATUS, 32'h03, 32'hff);
		rd(8'h10, 32'h0, 32'hffffffff);
		d = 9'($random(seed));
		set_a(d[7:0] & 8'h9f);
		rd(IDX_CTRL_A, {24'h0, d[7:0] & 8'h9f}, 32'hff);
		set_a(8'h40);
		bus(1'b1, IDX_CTRL_B, 32'h0c);
		foreach (fmts[i])
		begin
			set_a(fmts[i]);
			d = 9'($random(seed));
			send_char(d);
		end
		set_a(8'h40);
		cmp(32'h1, {31'h0, tx_oe});
		fq.push_back(11'h000);
		fq.push_back(11'h000); // Held request gives two breaks back to back
		bus(1'b1, IDX_CTRL_B, 32'h09);
		repeat (50) @(posedge clk);
		bus(1'b1, IDX_CTRL_B, 32'h08);
		drain();
		foreach (tie[i])
		begin
			bus(1'b1, IDX_CTRL_B, {24'h0, tie[i]});
			repeat (3) @(posedge clk);
			cmp({31'h0, tie[i][7] | tie[i][6]}, {31'h0, tx_irq});
		end
		bus(1'b1, IDX_CTRL_B, 32'h2c);
		d = 9'($random(seed));
		rx_char(d);
		cmp(32'h1, {31'h0, rx_irq});
		repeat (40) @(posedge clk); // Long enough for the line to count as idle
		rd(IDX_STATUS, 32'h0c, 32'h0c);
		rd(IDX_DATA, {23'h0, d[7], d[7:0]}, 32'h1ff);
		repeat (3) @(posedge clk);
		cmp(32'h0, {31'h0, rx_irq});
		set_a(8'h48);
		bus(1'b1, IDX_CTRL_B, 32'h2e);
		rx_char(9'h012);
		cmp(32'h0, {31'h0, rx_irq});
		rd(IDX_CTRL_B, 32'h2e, 32'hff);
		rx_char(9'h092);
		rd(IDX_CTRL_B, 32'h2c, 32'hff);
		repeat (40) @(posedge clk);
		rd(IDX_STATUS, 32'h0c, 32'h0c);
		rd(IDX_DATA, 32'h192, 32'h1ff);
		set_a(8'hc0);
		bus(1'b1, IDX_CTRL_B, 32'h0c);
		u_asp_remote.set_line(1'b0);
		send_char(9'h05a);
		rd(IDX_DATA, 32'h05a, 32'h1ff);
		u_asp_remote.set_line(1'b1);
		bus(1'b1, IDX_CTRL_B, 32'h8c);
		set_a(8'h00);
		repeat (3) @(posedge clk);
		cmp(32'h0, {31'h0, tx_irq});
		cmp(32'h0, {31'h0, tx_oe});
		rd(IDX_STATUS, 32'h03, 32'h03);
		repeat (10) @(posedge clk);
		give_verdict();
	end
endmodule // testbench
